// ---- dv/mfh_modem_model.sv ----
// Modulator and demodulator stand-in at the modem side of the queues
`timescale 1ns/1ps
module mfh_modem_model (
	input wire logic core_clk_i,
	input wire logic stall_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_parity_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic rx_ready_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o
);
	logic [8:0] got_q[$];

	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
	end

	// Stalling is the testbench's choice, so the modulator may be slow
	assign tx_ready_o = !stall_i;

	always @(posedge core_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got_q.push_back({tx_parity_i, tx_data_i});
		end
	end

	////////////////////////////////////////////////////////////////////////
	task send(input logic [7:0] v);
		@(negedge core_clk_i);
		rx_data_o = v;
		rx_valid_o = 1'b1;
		while (!rx_ready_i) @(negedge core_clk_i);
		@(negedge core_clk_i);
		rx_valid_o = 1'b0;
		// Inverse after release, so a stale byte cannot pass for a fresh one
		rx_data_o = ~v;
	endtask
endmodule // mfh_modem_model

// ---- dv/tb_mfh_modem_fifo.sv ----
// Register-level testbench of the modem queue block
`timescale 1ns/1ps
module tb_mfh_modem_fifo import mfh_pkg::*; ();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [7:0] tx_data;
	logic tx_par;
	logic tx_valid;
	logic tx_ready;
	logic tx_act = 1'b0;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ready;
	logic [1:0] cfg = 2'b00;
	logic xtal = 1'b0;
	logic filt = 1'b0;
	logic stall = 1'b1;
	logic ce = 1'b1;
	logic mode;
	logic ext;
	logic fen;
	logic inh;
	logic bst;
	logic bend;
	logic irq;
	mfh_clk_e csel;
	int n_errors = 0;
	int checks = 0;
	logic [7:0] v;
	logic [3:0] lv;
	int n;

	always #2 clk = ~clk;

	// Short babble unit keeps the guard test to a few dozen cycles
	mfh_modem_fifo #(.DEPTH(15), .BABBLE_UNIT_CYC(4)) mfh_modem_fifo_inst (
		.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.tx_data_o(tx_data), .tx_parity_o(tx_par), .tx_valid_o(tx_valid),
		.tx_ready_i(tx_ready), .tx_active_i(tx_act),
		.rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
		.clock_config_pins_i(cfg), .crystal_select_pin_i(xtal),
		.internal_filter_select_i(filt), .manchester_bus_mode_o(mode),
		.device_clock_sel_o(csel), .ext_clock_src_o(ext),
		.internal_filter_en_o(fen), .babble_inhibit_o(inh),
		.babble_inhibit_start_event_o(bst),
		.babble_inhibit_end_event_o(bend),
		.irq_o(irq)
	);

	mfh_modem_model mfh_modem_model_inst (
		.core_clk_i(clk), .stall_i(stall), .tx_data_i(tx_data),
		.tx_parity_i(tx_par), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid)
	);

	////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One idle cycle between accesses keeps each strobe a clean pulse
	task wr_reg(input logic [7:0] a, input logic [15:0] val);
		@(negedge clk);
		addr = a;
		wdata = val;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task chk_rd(input logic [7:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata & m, e);
	endtask

	task push(input logic [7:0] b);
		wr_reg(MFH_ADDR_TXQ, {7'h00, ~^b, b});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'h0200);
		chk_rd(MFH_ADDR_RXQ, 16'hFFFF, 16'h0200);
		chk_rd(MFH_ADDR_THR, 16'hFFFF, 16'h0000);
		chk_rd(MFH_ADDR_BABBLE, 16'hFFFF, 16'h0000);
		chk_rd(8'h26, 16'hFFFF, 16'h0000);
		chk_rd(MFH_ADDR_STATUS, 16'h000C, 16'h0004);
		chk_rd(MFH_ADDR_MASK, 16'hFFFF, 16'h0024);
		chk_rd(MFH_ADDR_CTRL, 16'hFFFF, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(MFH_ADDR_THR, 16'hFF34);
		chk_rd(MFH_ADDR_THR, 16'hFFFF, 16'h0034);
		wr_reg(MFH_ADDR_BABBLE, 16'hAB02);
		chk_rd(MFH_ADDR_BABBLE, 16'hFFFF, 16'h0002);
		// Modulator stalled: fill past full, the last push must drop
		for (int i = 0; i < 16; i++) begin
			push(8'h10 + 8'(i));
			if (i == 1) chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'h2000);
			if (i == 2) chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'h3800);
		end
		chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'hFC00);
		chk_rd(MFH_ADDR_STATUS, 16'h000C, 16'h0008);
		// Full is unmasked after reset; masking it must quiet irq only
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(MFH_ADDR_MASK, 16'h00FC);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0000);
		chk_rd(MFH_ADDR_MASK, 16'hFFFF, 16'h00FC);
		chk_rd(MFH_ADDR_STATUS, 16'h001C, 16'h0018);
		@(negedge clk);
		stall = 1'b0;
		repeat (20) @(negedge clk);
		chk(16'(mfh_modem_model_inst.got_q.size()), 16'h000F);
		for (int i = 0; i < 15; i++) begin
			v = 8'h10 + 8'(i);
			chk({7'h00, mfh_modem_model_inst.got_q[i]}, {7'h00, ~^v, v});
		end
		chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'h0200);
		// Receive side: a host write must not land, then fill and drain
		wr_reg(MFH_ADDR_RXQ, 16'h01FF);
		for (int k = 0; k < 15; k++) begin
			mfh_modem_model_inst.send(8'hC0 + 8'(k));
		end
		chk({15'h0000, rx_ready}, 16'h0000);
		for (int k = 0; k < 15; k++) begin
			v = 8'hC0 + 8'(k);
			lv = 4'(15 - k);
			chk_rd(MFH_ADDR_RXQ, 16'hFFFF,
				{lv, lv >= 4'h4, k == 0, 1'b0, ~^v, v});
		end
		chk_rd(MFH_ADDR_RXQ, 16'hFFFF, 16'h0200);
		// Loopback moves transmit entries straight into the receive queue
		wr_reg(MFH_ADDR_CTRL, 16'h0004);
		push(8'h5A);
		push(8'h3C);
		repeat (6) @(negedge clk);
		chk_rd(MFH_ADDR_RXQ, 16'hFFFF, {7'h10, ~^8'h5A, 8'h5A});
		chk_rd(MFH_ADDR_RXQ, 16'hFFFF, {7'h08, ~^8'h3C, 8'h3C});
		wr_reg(MFH_ADDR_CTRL, 16'h0000);
		chk(16'(mfh_modem_model_inst.got_q.size()), 16'h000F);
		// Babble guard: setting 2 with a 4-cycle unit cuts in near 8 cycles
		@(negedge clk);
		tx_act = 1'b1;
		n = 0;
		while (!inh && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, n >= 8 && n <= 10}, 16'h0001);
		chk({14'h0000, bst, inh}, 16'h0003);
		chk_rd(MFH_ADDR_STATUS, 16'h2000, 16'h2000);
		tx_act = 1'b0;
		@(negedge clk);
		chk({14'h0000, bend, inh}, 16'h0002);
		repeat (2) @(negedge clk);
		chk({13'h0000, bst, bend, inh}, 16'h0000);
		// Every clock-configuration and crystal pin combination, filter pin set to ~cfg[0], after the synchroniser has settled
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			cfg = 2'(i);
			xtal = i[2];
			filt = ~i[0];
			repeat (5) @(negedge clk);
			chk({11'h000, mode, csel, ext, fen}, {11'h000, cfg[1],
				cfg[1] ? 2'b10 : {1'b0, cfg[0]}, xtal | (cfg == 2'b11),
				filt});
		end
		// Clock enable low freezes the block, so a write cannot land
		ce = 1'b0;
		push(8'h77);
		ce = 1'b1;
		chk_rd(MFH_ADDR_TXQ, 16'hFE00, 16'h0200);
		conclude();
	end
endmodule // tb_mfh_modem_fifo

// ---- verilog/mfh_babble_timer.sv ----
// Transmit babble guard: cuts a transmission that runs past its time limit
`timescale 1ns/1ps
module mfh_babble_timer import mfh_pkg::*; #(
	parameter int UNIT_CYC = MFH_BABBLE_UNIT_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tx_active_i,
	input wire logic [7:0] limit_i,
	output logic inhibit_o,
	output logic start_o,
	output logic end_o
);
	localparam int PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
	mfh_bab_e state;
	mfh_bab_e next_state;
	logic [PW-1:0] pre;
	logic [7:0] ticks;
	logic tick;

	assign tick = (pre == PW'(UNIT_CYC - 1));

	always_comb begin
		next_state = state;
		case (state)
			MFH_BAB_IDLE: begin
				if (tx_active_i && (limit_i != 8'h00)) begin
					next_state = MFH_BAB_COUNT;
				end
			end
			MFH_BAB_COUNT: begin
				if (!tx_active_i) begin
					next_state = MFH_BAB_IDLE;
				end else if (tick && (8'(ticks + 1'b1) >= limit_i)) begin
					next_state = MFH_BAB_INHIBIT;
				end
			end
			MFH_BAB_INHIBIT: begin
				if (!tx_active_i) begin
					next_state = MFH_BAB_IDLE;
				end
			end
			default: next_state = MFH_BAB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= MFH_BAB_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// Prescaler and unit count restart whenever counting is left
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pre <= '0;
			ticks <= 8'h00;
		end else if (ce_i) begin
			if (state != MFH_BAB_COUNT) begin
				pre <= '0;
				ticks <= 8'h00;
			end else if (tick) begin
				pre <= '0;
				ticks <= 8'(ticks + 1'b1);
			end else begin
				pre <= PW'(pre + 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			inhibit_o <= 1'b0;
			start_o <= 1'b0;
			end_o <= 1'b0;
		end else if (ce_i) begin
			inhibit_o <= (next_state == MFH_BAB_INHIBIT);
			start_o <= (next_state == MFH_BAB_INHIBIT) &&
				(state != MFH_BAB_INHIBIT);
			end_o <= (state == MFH_BAB_INHIBIT) &&
				(next_state != MFH_BAB_INHIBIT);
		end
	end

	AST_BABBLE_DISABLED: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && (limit_i == 8'h00) && (state == MFH_BAB_IDLE))
		|=> !inhibit_o)
		else $error("babble guard fired with a zero limit");
endmodule // mfh_babble_timer

// ---- verilog/mfh_fifo.sv ----
// Byte queue with its own storage, level count and registered head entry
`timescale 1ns/1ps
module mfh_fifo import mfh_pkg::*; #(
	parameter int W = 9,
	parameter int DEPTH = 15,
	parameter int LW = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic push_i,
	input wire logic [W-1:0] push_data_i,
	input wire logic pop_i,
	output logic [W-1:0] head_o,
	output logic [LW-1:0] level_o,
	output logic full_o,
	output logic empty_o
);
	logic [W-1:0] mem [DEPTH];
	logic [LW-1:0] wr_ptr;
	logic [LW-1:0] rd_ptr;
	logic [LW-1:0] next_rd_ptr;
	logic do_push;
	logic do_pop;

	function automatic logic [LW-1:0] wrap_inc(input logic [LW-1:0] p);
		return (p == LW'(DEPTH - 1)) ? '0 : LW'(p + 1'b1);
	endfunction

	assign full_o = (level_o == LW'(DEPTH));
	assign empty_o = (level_o == '0);
	// Full refuses a push even with a pop, so no slot is overwritten
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	assign next_rd_ptr = do_pop ? wrap_inc(rd_ptr) : rd_ptr;

	always_ff @(posedge core_clk_i) begin
		if (ce_i && do_push) begin
			mem[wr_ptr] <= push_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (ce_i) begin
			if (do_push) begin
				wr_ptr <= wrap_inc(wr_ptr);
			end
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			level_o <= '0;
		end else if (ce_i) begin
			level_o <= LW'(level_o + LW'(do_push) - LW'(do_pop));
		end
	end

	// Bypass keeps the head current when a push lands on the next slot
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			head_o <= '0;
		end else if (ce_i) begin
			if (do_push && (wr_ptr == next_rd_ptr)) begin
				head_o <= push_data_i;
			end else begin
				head_o <= mem[next_rd_ptr];
			end
		end
	end
endmodule // mfh_fifo

// ---- verilog/mfh_modem_fifo.sv ----
// Host-side queue registers, mode pins and babble guard of the modem
// Summary of operation
// - Host writes transmit byte to bits 7-0 of transmit port; device queues it.
// - Receive port bit 8 shows odd parity of the received byte.
// - Receive port bits 7-0 return next demodulated byte; register read-only.
// - Bits 15-12 of each queue port give that queue's entry count.
// - Bit 11 of each queue port sets once level reaches its threshold.
// - Bit 10 of each queue port is set while that queue is full.
// - Bit 9 set while queue empty; both ports reset to 0x0200.
// - Host programs thresholds 1 to 15; device compares queue level to them.
// - Threshold bits 7-4 belong to modulator-side queue, read/write, reset zero.
// - Threshold bits 3-0 belong to demodulator-side queue; bits 15-8 read zero.
// - Babble timeout is bits 7-0 times 2.048 ms; upper bits reserved.
// - Clock-configuration pins choose tone mode or Manchester bus mode.
// - Manchester mode runs 31.25 kbit/s; tone mode uses 1200/2200 Hz.
// - Device clock is 1.2288 or 3.686 MHz in tone, 4 MHz Manchester.
// - Configuration pins with crystal pin pick internal oscillator or external clock.
// - Filter-select high uses internal bandpass filter; low the external path.
// - Loopback enable in control register feeds transmit queue into receive queue.
// - Masked queue events stay visible in status but never raise irq.
// - Status register bits 3 and 2 mirror transmit queue full and empty.
`timescale 1ns/1ps
module mfh_modem_fifo import mfh_pkg::*; #(
	parameter int DEPTH = MFH_FIFO_DEPTH,
	parameter int BABBLE_UNIT_CYC = MFH_BABBLE_UNIT_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic [7:0] tx_data_o,
	output logic tx_parity_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic tx_active_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [1:0] clock_config_pins_i,
	input wire logic crystal_select_pin_i,
	input wire logic internal_filter_select_i,
	output logic manchester_bus_mode_o,
	output mfh_clk_e device_clock_sel_o,
	output logic ext_clock_src_o,
	output logic internal_filter_en_o,
	output logic babble_inhibit_o,
	output logic babble_inhibit_start_event_o,
	output logic babble_inhibit_end_event_o,
	output logic irq_o
);
	localparam int LW = MFH_LEVEL_W;

	////////////////////////////////////////////////////////////////////////
	// Registers written by the host
	logic [15:0] irq_mask;
	logic loopback_enable;
	logic [MFH_THR_W-1:0] modulator_side_threshold;
	logic [MFH_THR_W-1:0] demodulator_side_threshold;
	logic [7:0] babble_timeout_setting;
	logic wr_hit;

	assign wr_hit = ce_i && reg_wr_i;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irq_mask <= MFH_MASK_RESET;
			loopback_enable <= 1'b0;
			modulator_side_threshold <= MFH_THR_RESET[MFH_TX_THR_LSB +: 4];
			demodulator_side_threshold <= MFH_THR_RESET[MFH_RX_THR_LSB +: 4];
			babble_timeout_setting <= MFH_BABBLE_RESET;
		end else if (wr_hit) begin
			case (reg_addr_i)
				MFH_ADDR_MASK: irq_mask <= reg_wdata_i;
				MFH_ADDR_CTRL: begin
					loopback_enable <= reg_wdata_i[MFH_CTRL_LOOP_BIT];
				end
				MFH_ADDR_THR: begin
					modulator_side_threshold <=
						reg_wdata_i[MFH_TX_THR_LSB +: MFH_THR_W];
					demodulator_side_threshold <=
						reg_wdata_i[MFH_RX_THR_LSB +: MFH_THR_W];
				end
				MFH_ADDR_BABBLE: babble_timeout_setting <= reg_wdata_i[7:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The two queues
	logic [MFH_ENTRY_W-1:0] tx_head;
	logic [MFH_ENTRY_W-1:0] rx_head;
	logic [MFH_ENTRY_W-1:0] rx_push_data;
	logic [LW-1:0] tx_level;
	logic [LW-1:0] rx_level;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic tx_lvl_flag;
	logic rx_lvl_flag;

	// Parity bit is stored as the host gave it, never recomputed
	assign tx_push = reg_wr_i && (reg_addr_i == MFH_ADDR_TXQ);
	// Babble guard holds the queue so no byte is lost while cut off
	assign tx_pop = !tx_empty && !babble_inhibit_o &&
		(loopback_enable ? !rx_full : tx_ready_i);
	assign tx_valid_o = !tx_empty && !loopback_enable && !babble_inhibit_o;
	assign tx_data_o = tx_head[7:0];
	assign tx_parity_o = tx_head[MFH_PARITY_BIT];

	assign rx_ready_o = !rx_full && !loopback_enable;
	assign rx_push = loopback_enable ? tx_pop : rx_valid_i;
	assign rx_push_data = loopback_enable ? tx_head :
		{~^rx_data_i, rx_data_i};
	assign rx_pop = reg_rd_i && (reg_addr_i == MFH_ADDR_RXQ);

	mfh_fifo #(.W(MFH_ENTRY_W), .DEPTH(DEPTH), .LW(LW)) u_tx_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.push_i(tx_push),
		.push_data_i(reg_wdata_i[MFH_ENTRY_W-1:0]),
		.pop_i(tx_pop),
		.head_o(tx_head),
		.level_o(tx_level),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	mfh_fifo #(.W(MFH_ENTRY_W), .DEPTH(DEPTH), .LW(LW)) u_rx_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.push_i(rx_push),
		.push_data_i(rx_push_data),
		.pop_i(rx_pop),
		.head_o(rx_head),
		.level_o(rx_level),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	// A zero threshold is outside the legal range and never raises the flag
	assign tx_lvl_flag = (modulator_side_threshold != '0) &&
		(tx_level >= modulator_side_threshold);
	assign rx_lvl_flag = (demodulator_side_threshold != '0) &&
		(rx_level >= demodulator_side_threshold);

	////////////////////////////////////////////////////////////////////////
	// Status, interrupt and read data
	logic [MFH_ST_EV_W-1:0] queue_events;
	logic [15:0] status_word;
	logic [15:0] next_rdata;

	assign queue_events = {rx_lvl_flag, rx_full, rx_empty,
		tx_lvl_flag, tx_full, tx_empty};

	always_comb begin
		status_word = 16'h0000;
		status_word[MFH_ST_EV_LSB +: MFH_ST_EV_W] = queue_events;
		status_word[MFH_ST_INHIBIT] = babble_inhibit_o;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(queue_events &
				~irq_mask[MFH_ST_EV_LSB +: MFH_ST_EV_W]);
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr_i)
			MFH_ADDR_STATUS: next_rdata = status_word;
			MFH_ADDR_MASK: next_rdata = irq_mask;
			MFH_ADDR_CTRL: next_rdata[MFH_CTRL_LOOP_BIT] = loopback_enable;
			MFH_ADDR_TXQ: begin
				next_rdata[MFH_LEVEL_LSB +: LW] = tx_level;
				next_rdata[MFH_LVL_FLAG_BIT] = tx_lvl_flag;
				next_rdata[MFH_FULL_BIT] = tx_full;
				next_rdata[MFH_EMPTY_BIT] = tx_empty;
			end
			MFH_ADDR_RXQ: begin
				next_rdata[MFH_LEVEL_LSB +: LW] = rx_level;
				next_rdata[MFH_LVL_FLAG_BIT] = rx_lvl_flag;
				next_rdata[MFH_FULL_BIT] = rx_full;
				next_rdata[MFH_EMPTY_BIT] = rx_empty;
				if (!rx_empty) begin
					next_rdata[MFH_ENTRY_W-1:0] = rx_head;
				end
			end
			MFH_ADDR_THR: begin
				next_rdata[MFH_TX_THR_LSB +: MFH_THR_W] =
					modulator_side_threshold;
				next_rdata[MFH_RX_THR_LSB +: MFH_THR_W] =
					demodulator_side_threshold;
			end
			MFH_ADDR_BABBLE: next_rdata[7:0] = babble_timeout_setting;
			default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= MFH_RDATA_RESET;
		end else if (ce_i && reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode, clock and filter pins
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;

	// First stage feeds only the second; pins may move at any time
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else if (ce_i) begin
			pin_meta <= {internal_filter_select_i, crystal_select_pin_i,
				clock_config_pins_i};
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			manchester_bus_mode_o <= 1'b0;
			device_clock_sel_o <= MFH_CLK_1M2288;
			ext_clock_src_o <= 1'b0;
			internal_filter_en_o <= 1'b0;
		end else if (ce_i) begin
			// Manchester mode: 31.25 kbit/s; tone mode: 1200/2200 Hz
			manchester_bus_mode_o <= pin_sync[1];
			if (pin_sync[1]) begin
				device_clock_sel_o <= MFH_CLK_4M;
			end else if (pin_sync[0]) begin
				device_clock_sel_o <= MFH_CLK_3M686;
			end else begin
				device_clock_sel_o <= MFH_CLK_1M2288;
			end
			ext_clock_src_o <= pin_sync[2] || (pin_sync[1:0] == 2'b11);
			internal_filter_en_o <= pin_sync[3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Babble guard
	mfh_babble_timer #(.UNIT_CYC(BABBLE_UNIT_CYC)) u_babble (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tx_active_i(tx_active_i),
		.limit_i(babble_timeout_setting),
		.inhibit_o(babble_inhibit_o),
		.start_o(babble_inhibit_start_event_o),
		.end_o(babble_inhibit_end_event_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_TX_QUEUED: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(wr_hit && tx_push && !tx_full && !tx_pop)
		|=> tx_level == LW'($past(tx_level) + 1'b1))
		else $error("accepted transmit write did not raise level");
	AST_TX_FULL_DROP: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(wr_hit && tx_push && tx_full) |=> tx_level ==
			LW'($past(tx_level) - LW'($past(tx_pop))))
		else $error("write to full transmit queue changed level");

	AST_RX_POP: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && rx_pop && !rx_empty && !rx_push)
		|=> rx_level == LW'($past(rx_level) - 1'b1))
		else $error("receive read did not remove one entry");

	AST_RX_DATA: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && rx_pop && !rx_empty)
		|=> reg_rdata_o[MFH_ENTRY_W-1:0] == $past(rx_head))
		else $error("receive read returned wrong entry");

	AST_LEVEL_FIELD: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == MFH_ADDR_TXQ)
		|=> reg_rdata_o[MFH_LEVEL_LSB +: LW] == $past(tx_level))
		else $error("transmit level field wrong");

	AST_EMPTY_FIELD: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == MFH_ADDR_RXQ)
		|=> reg_rdata_o[MFH_EMPTY_BIT] == ($past(rx_level) == '0))
		else $error("receive empty bit wrong");

	AST_FULL_FIELD: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == MFH_ADDR_TXQ)
		|=> reg_rdata_o[MFH_FULL_BIT] == ($past(tx_level) == LW'(DEPTH)))
		else $error("transmit full bit wrong");
	AST_LEVEL_FLAG: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == MFH_ADDR_RXQ) |=>
			reg_rdata_o[MFH_LVL_FLAG_BIT] ==
			($past(demodulator_side_threshold) != '0 &&
			$past(rx_level) >= $past(demodulator_side_threshold)))
		else $error("receive level flag wrong");

	AST_STATUS_MIRROR: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == MFH_ADDR_STATUS)
		|=> reg_rdata_o[MFH_ST_TX_FULL:MFH_ST_TX_EMPTY] ==
			{$past(tx_full), $past(tx_empty)})
		else $error("status does not mirror transmit queue");

	AST_LOOPBACK: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(ce_i && loopback_enable && !tx_empty && !rx_full &&
			!babble_inhibit_o && !rx_pop)
		|=> rx_level == LW'($past(rx_level) + 1'b1))
		else $error("loopback did not move a byte");
	AST_IRQ_MASK: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		$past(ce_i) |-> irq_o == $past(|(queue_events &
			~irq_mask[MFH_ST_EV_LSB +: MFH_ST_EV_W])))
		else $error("irq does not follow unmasked events");
endmodule // mfh_modem_fifo

// ---- verilog/mfh_pkg.sv ----
// Register map, field layout, reset values and timing of the modem FIFO block
package mfh_pkg;
	// Register offsets
	localparam logic [7:0] MFH_ADDR_STATUS = 8'h20;
	localparam logic [7:0] MFH_ADDR_MASK = 8'h21;
	localparam logic [7:0] MFH_ADDR_CTRL = 8'h22;
	localparam logic [7:0] MFH_ADDR_TXQ = 8'h23;
	localparam logic [7:0] MFH_ADDR_RXQ = 8'h24;
	localparam logic [7:0] MFH_ADDR_THR = 8'h25;
	localparam logic [7:0] MFH_ADDR_BABBLE = 8'h27;
	// Reset values
	localparam logic [15:0] MFH_QUEUE_RESET = 16'h0200;
	localparam logic [15:0] MFH_MASK_RESET = 16'h0024;
	localparam logic [7:0] MFH_THR_RESET = 8'h00;
	localparam logic [7:0] MFH_BABBLE_RESET = 8'h00;
	localparam logic [15:0] MFH_RDATA_RESET = 16'h0000;
	// Queue register fields
	localparam int MFH_LEVEL_LSB = 12;
	localparam int MFH_LEVEL_W = 4;
	localparam int MFH_LVL_FLAG_BIT = 11;
	localparam int MFH_FULL_BIT = 10;
	localparam int MFH_EMPTY_BIT = 9;
	localparam int MFH_PARITY_BIT = 8;
	localparam int MFH_ENTRY_W = 9;
	// Threshold and control fields
	localparam int MFH_TX_THR_LSB = 4;
	localparam int MFH_RX_THR_LSB = 0;
	localparam int MFH_THR_W = 4;
	localparam int MFH_CTRL_LOOP_BIT = 2;
	// Status fields
	localparam int MFH_ST_EV_LSB = 2;
	localparam int MFH_ST_EV_W = 6;
	localparam int MFH_ST_TX_EMPTY = 2;
	localparam int MFH_ST_TX_FULL = 3;
	localparam int MFH_ST_INHIBIT = 13;
	// Queue depth
	localparam int MFH_FIFO_DEPTH = 15;
	// Timing
	localparam int MFH_CLK_PERIOD_NS = 4;
	localparam int MFH_BABBLE_UNIT_NS = 2048000;
	localparam int MFH_BABBLE_UNIT_CYC = MFH_BABBLE_UNIT_NS / MFH_CLK_PERIOD_NS;
	// Line figures of the two modes
	localparam int MFH_MANCH_BIT_RATE_BPS = 31250;
	localparam int MFH_TONE_MARK_HZ = 1200;
	localparam int MFH_TONE_SPACE_HZ = 2200;
	// Device clock choices
	typedef enum logic [1:0] {
		MFH_CLK_1M2288 = 2'b00,
		MFH_CLK_3M686 = 2'b01,
		MFH_CLK_4M = 2'b10
	} mfh_clk_e;
	typedef enum logic [1:0] {
		MFH_BAB_IDLE = 2'b00,
		MFH_BAB_COUNT = 2'b01,
		MFH_BAB_INHIBIT = 2'b10
	} mfh_bab_e;
endpackage
